// *** rtl/camera_event_notifier.sv ***
// Event notifier: watches camera events, emits identified timestamped messages
//
// Functional notes
// - Select codes 0..9 and 28/29 address capture, frame, exposure, line.
// - Each source has an enable, off at reset, written via the selector.
// - An enabled source gives one message for all its occurrences before that message is taken, none if off.
// - Capture begin is tagged 0x9011 and capture end 0x9012.
// - A 64-bit timestamp is latched at the event; zero before any event.
// - The frame sequence number is captured with each event.
// - Frame begin/end are 0x9300/0x9301, line begin/end 0x9330/0x9331.
// - Colour build has red 0x9302/3, green 0x9304/5 and blue 0x9306/7.
// - Mono build has one exposure pair tagged 0x9304 and 0x9305.
`timescale 1ns/1ps
module camera_event_notifier
	import event_notifier_pkg::*;
#(
	parameter bit COLOR_MODEL = 1'b1              // 1 colour, 0 monochrome
)(
	input  wire logic               ref_clk,            // 10 MHz clock
	input  wire logic               reset,              // Sync reset, high
	input  wire logic               clk_en,             // Freezes state
	input  wire logic [4:0]         event_source_select,// Source code
	input  wire logic               notify_write,       // Write strobe
	input  wire logic               notify_enable_in,   // Enable to write
	input  wire logic               capture_begin,      // Event pulse
	input  wire logic               capture_end,        // Event pulse
	input  wire logic               frame_begin,        // Event pulse
	input  wire logic               frame_end_a,        // Event pulse
	input  wire logic [2:0]         exposure_begin,     // Blue,green,red
	input  wire logic [2:0]         exposure_end,       // Blue,green,red
	input  wire logic               line_active_window, // Line valid level
	input  wire logic [TS_W-1:0]    timestamp,          // Time counter
	input  wire logic [FRAME_W-1:0] frame_sequence_number, // Frame count
	input  wire logic               msg_ready,          // Channel accepts
	output logic                    notify_enable,      // Selected enable
	output logic                    select_valid,       // Select is mapped
	output logic                    msg_valid,          // Message on outputs
	output logic [15:0]             event_identifier,   // Message id
	output logic [TS_W-1:0]         msg_timestamp,      // Message time
	output logic [FRAME_W-1:0]      msg_frame           // Message frame
);

	// ========================================================================
	// Source decode
	logic [3:0] sel_slot;
	logic       sel_hit;

	// Red and blue do not exist on the monochrome build
	always_comb begin
		sel_slot = 4'h0;
		sel_hit  = 1'b1;
		case (event_source_select)
			SRC_CAP_BEGIN:   sel_slot = 4'h0;
			SRC_CAP_END:     sel_slot = 4'h1;
			SRC_FRAME_BEGIN: sel_slot = 4'h2;
			SRC_FRAME_END:   sel_slot = 4'h3;
			SRC_RED_BEGIN: begin
				sel_slot = 4'h4;
				sel_hit  = COLOR_MODEL;
			end
			SRC_RED_END: begin
				sel_slot = 4'h5;
				sel_hit  = COLOR_MODEL;
			end
			SRC_GRN_BEGIN:   sel_slot = 4'h6;
			SRC_GRN_END:     sel_slot = 4'h7;
			SRC_BLUE_BEGIN: begin
				sel_slot = 4'h8;
				sel_hit  = COLOR_MODEL;
			end
			SRC_BLUE_END: begin
				sel_slot = 4'h9;
				sel_hit  = COLOR_MODEL;
			end
			SRC_LINE_BEGIN:  sel_slot = 4'ha;
			SRC_LINE_END:    sel_slot = 4'hb;
			default:         sel_hit  = 1'b0;
		endcase
	end

	// ========================================================================
	// Enables
	logic [NUM_SOURCES-1:0] enables;
	logic [NUM_SOURCES-1:0] next_enables;

	always_comb begin
		next_enables = enables;
		if (notify_write && sel_hit) begin
			next_enables[sel_slot] = notify_enable_in;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			enables <= ENABLE_RESET;
		end else if (clk_en) begin
			enables <= next_enables;
		end
	end

	// ========================================================================
	// Event edge detection on the line window level
	logic line_prev;
	logic next_line_prev;

	assign next_line_prev = line_active_window;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			line_prev <= 1'b0;
		end else if (clk_en) begin
			line_prev <= next_line_prev;
		end
	end

	logic [NUM_SOURCES-1:0] pulses;
	logic [15:0]            ids [NUM_SOURCES];

	// Mono build reports its single exposure pair on the green slots
	always_comb begin
		pulses[0]  = capture_begin;
		pulses[1]  = capture_end;
		pulses[2]  = frame_begin;
		pulses[3]  = frame_end_a;
		pulses[4]  = COLOR_MODEL & exposure_begin[0];
		pulses[5]  = COLOR_MODEL & exposure_end[0];
		pulses[6]  = exposure_begin[1];
		pulses[7]  = exposure_end[1];
		pulses[8]  = COLOR_MODEL & exposure_begin[2];
		pulses[9]  = COLOR_MODEL & exposure_end[2];
		pulses[10] = line_active_window & ~line_prev;
		pulses[11] = ~line_active_window & line_prev;
		ids[0]  = ID_CAP_BEGIN;
		ids[1]  = ID_CAP_END;
		ids[2]  = ID_FRAME_BEGIN;
		ids[3]  = ID_FRAME_END;
		ids[4]  = ID_RED_BEGIN;
		ids[5]  = ID_RED_END;
		ids[6]  = ID_GRN_BEGIN;
		ids[7]  = ID_GRN_END;
		ids[8]  = ID_BLUE_BEGIN;
		ids[9]  = ID_BLUE_END;
		ids[10] = ID_LINE_BEGIN;
		ids[11] = ID_LINE_END;
	end

	// ========================================================================
	// Per-source slots
	logic [NUM_SOURCES-1:0] pending;
	logic [NUM_SOURCES-1:0] taken;
	logic [TS_W-1:0]        slot_ts    [NUM_SOURCES];
	logic [FRAME_W-1:0]     slot_frame [NUM_SOURCES];

	for (genvar i = 0; i < NUM_SOURCES; i++) begin : g_slot
		source_slot u_slot (
			.ref_clk     (ref_clk),
			.reset       (reset),
			.clk_en      (clk_en),
			.enable      (enables[i]),
			.event_pulse (pulses[i]),
			.timestamp   (timestamp),
			.frame_num   (frame_sequence_number),
			.taken       (taken[i]),
			.pending     (pending[i]),
			.held_ts     (slot_ts[i]),
			.held_frame  (slot_frame[i])
		);
	end

	// ========================================================================
	// Emitter: lowest pending slot first, one message at a time
	emit_state_t            state;
	emit_state_t            next_state;
	logic [3:0]             pick;
	logic                   any_pending;
	logic                   next_msg_valid;
	logic [15:0]            next_event_identifier;
	logic [TS_W-1:0]        next_msg_timestamp;
	logic [FRAME_W-1:0]     next_msg_frame;

	always_comb begin
		pick        = 4'h0;
		any_pending = 1'b0;
		for (int k = NUM_SOURCES - 1; k >= 0; k--) begin
			if (pending[k]) begin
				pick        = 4'(k);
				any_pending = 1'b1;
			end
		end
	end

	// A slot is released only when loaded; a slot re-fired meanwhile is kept
	always_comb begin
		next_state            = state;
		next_msg_valid        = msg_valid;
		next_event_identifier = event_identifier;
		next_msg_timestamp    = msg_timestamp;
		next_msg_frame        = msg_frame;
		taken                 = '0;
		case (state)
			EMIT_IDLE: begin
				if (any_pending) begin
					taken[pick]           = 1'b1;
					next_msg_valid        = 1'b1;
					next_event_identifier = ids[pick];
					next_msg_timestamp    = slot_ts[pick];
					next_msg_frame        = slot_frame[pick];
					next_state            = EMIT_SEND;
				end
			end
			EMIT_SEND: begin
				if (msg_ready) begin
					next_msg_valid = 1'b0;
					next_state     = EMIT_IDLE;
				end
			end
			default: begin
				next_msg_valid = 1'b0;
				next_state     = EMIT_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state            <= EMIT_IDLE;
			msg_valid        <= 1'b0;
			event_identifier <= 16'h0000;
			msg_timestamp    <= TS_RESET;
			msg_frame        <= FRAME_RESET;
			notify_enable    <= 1'b0;
			select_valid     <= 1'b0;
		end else if (clk_en) begin
			state            <= next_state;
			msg_valid        <= next_msg_valid;
			event_identifier <= next_event_identifier;
			msg_timestamp    <= next_msg_timestamp;
			msg_frame        <= next_msg_frame;
			notify_enable    <= sel_hit & next_enables[sel_slot];
			select_valid     <= sel_hit;
		end
	end

endmodule

// *** common/event_notifier_pkg.sv ***
// Constants and types shared by the camera event notifier
package event_notifier_pkg;

	// ========================================================================
	// Source codes on the select field
	localparam int          NUM_SOURCES  = 12;
	localparam logic [4:0]  SRC_CAP_BEGIN   = 5'h00;
	localparam logic [4:0]  SRC_CAP_END     = 5'h01;
	localparam logic [4:0]  SRC_FRAME_BEGIN = 5'h02;
	localparam logic [4:0]  SRC_FRAME_END   = 5'h03;
	localparam logic [4:0]  SRC_RED_BEGIN   = 5'h04;
	localparam logic [4:0]  SRC_RED_END     = 5'h05;
	localparam logic [4:0]  SRC_GRN_BEGIN   = 5'h06;
	localparam logic [4:0]  SRC_GRN_END     = 5'h07;
	localparam logic [4:0]  SRC_BLUE_BEGIN  = 5'h08;
	localparam logic [4:0]  SRC_BLUE_END    = 5'h09;
	localparam logic [4:0]  SRC_LINE_BEGIN  = 5'h1c;
	localparam logic [4:0]  SRC_LINE_END    = 5'h1d;

	// ========================================================================
	// Message identifiers, indexed by internal slot 0..11
	localparam logic [15:0] ID_CAP_BEGIN   = 16'h9011;
	localparam logic [15:0] ID_CAP_END     = 16'h9012;
	localparam logic [15:0] ID_FRAME_BEGIN = 16'h9300;
	localparam logic [15:0] ID_FRAME_END   = 16'h9301;
	localparam logic [15:0] ID_RED_BEGIN   = 16'h9302;
	localparam logic [15:0] ID_RED_END     = 16'h9303;
	localparam logic [15:0] ID_GRN_BEGIN   = 16'h9304;
	localparam logic [15:0] ID_GRN_END     = 16'h9305;
	localparam logic [15:0] ID_BLUE_BEGIN  = 16'h9306;
	localparam logic [15:0] ID_BLUE_END    = 16'h9307;
	localparam logic [15:0] ID_LINE_BEGIN  = 16'h9330;
	localparam logic [15:0] ID_LINE_END    = 16'h9331;

	// ========================================================================
	// Widths and reset values
	localparam int          TS_W         = 64;
	localparam int          FRAME_W      = 32;
	localparam logic [63:0] TS_RESET     = 64'h0;
	localparam logic [31:0] FRAME_RESET  = 32'h0;
	localparam logic [11:0] ENABLE_RESET = 12'h000;

	typedef enum logic [1:0] {
		EMIT_IDLE = 2'b00,
		EMIT_SEND = 2'b01
	} emit_state_t;

endpackage

// *** rtl/source_slot.sv ***
// One event source slot: pending flag with latched timestamp and frame
`timescale 1ns/1ps
module source_slot
	import event_notifier_pkg::*;
(
	input  wire logic               ref_clk,     // System clock
	input  wire logic               reset,       // Sync reset, high
	input  wire logic               clk_en,      // Freezes state when low
	input  wire logic               enable,      // Notification enabled
	input  wire logic               event_pulse, // Event occurrence
	input  wire logic [TS_W-1:0]    timestamp,   // Free-running time
	input  wire logic [FRAME_W-1:0] frame_num,   // Current frame number
	input  wire logic               taken,       // Slot emitted this cycle
	output logic                    pending,     // Message waiting
	output logic [TS_W-1:0]         held_ts,     // Latched timestamp
	output logic [FRAME_W-1:0]      held_frame   // Latched frame number
);

	logic               next_pending;
	logic [TS_W-1:0]    next_held_ts;
	logic [FRAME_W-1:0] next_held_frame;

	// A fresh event in the same cycle as the take re-arms the slot
	always_comb begin
		next_pending    = pending;
		next_held_ts    = held_ts;
		next_held_frame = held_frame;
		if (taken) begin
			next_pending = 1'b0;
		end
		if (enable && event_pulse) begin
			next_pending    = 1'b1;
			next_held_ts    = timestamp;
			next_held_frame = frame_num;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pending    <= 1'b0;
			held_ts    <= TS_RESET;
			held_frame <= FRAME_RESET;
		end else if (clk_en) begin
			pending    <= next_pending;
			held_ts    <= next_held_ts;
			held_frame <= next_held_frame;
		end
	end

endmodule

// *** tb/notifier_checker.sv ***
// Port-level assertions for the camera event notifier
`timescale 1ns/1ps
module notifier_checker
	import event_notifier_pkg::*;
#(
	parameter bit COLOR_MODEL = 1'b1 // Build variant
)(
	input wire logic               ref_clk,             // Clock
	input wire logic               reset,               // Sync reset
	input wire logic               clk_en,              // Run enable
	input wire logic [4:0]         event_source_select, // Source code
	input wire logic               notify_write,        // Write strobe
	input wire logic               notify_enable_in,    // Written value
	input wire logic               msg_ready,           // Channel accepts
	input wire logic               notify_enable,       // Selected enable
	input wire logic               select_valid,        // Select mapped
	input wire logic               msg_valid,           // Message present
	input wire logic [15:0]        event_identifier,    // Message id
	input wire logic [TS_W-1:0]    msg_timestamp,       // Message time
	input wire logic [FRAME_W-1:0] msg_frame            // Message frame
);
	logic mapped;

	// Mono build has no red or blue codes
	always_comb begin
		mapped = (event_source_select <= 5'h09) &&
			(COLOR_MODEL || !(event_source_select inside
			{5'h04, 5'h05, 5'h08, 5'h09}));
		mapped = mapped || (event_source_select inside {5'h1c, 5'h1d});
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);

	// ========================================================================
	// Message channel
	stable_msg_a: assert property (
		clk_en && msg_valid && !msg_ready |=> msg_valid &&
		$stable(event_identifier) && $stable(msg_timestamp) &&
		$stable(msg_frame)) else $error("message changed while held");
	one_send_a: assert property (
		clk_en && msg_valid && msg_ready |=> !msg_valid)
		else $error("message offered again after accept");
	id_known_a: assert property (
		msg_valid |-> event_identifier inside {16'h9011, 16'h9012,
		[16'h9300:16'h9307], 16'h9330, 16'h9331})
		else $error("unknown message identifier");
	freeze_a: assert property (
		!clk_en |=> $stable(msg_valid) && $stable(notify_enable))
		else $error("state moved while frozen");

	// ========================================================================
	// Selector and enables
	select_map_a: assert property (
		clk_en |=> select_valid == $past(mapped))
		else $error("select valid flag wrong");
	unmapped_off_a: assert property (
		!select_valid |-> !notify_enable)
		else $error("enable shown for unmapped code");
	write_on_a: assert property (
		clk_en && notify_write && notify_enable_in && mapped
		|=> notify_enable) else $error("enable write lost");
	write_off_a: assert property (
		clk_en && notify_write && !notify_enable_in |=> !notify_enable)
		else $error("disable write lost");

	cover property (msg_valid && msg_ready);
	cover property (msg_valid && !msg_ready && !clk_en);
	cover property (clk_en && notify_write && !mapped);
endmodule

bind camera_event_notifier notifier_checker #(.COLOR_MODEL(COLOR_MODEL))
	chk_u (.ref_clk, .reset, .clk_en, .event_source_select, .notify_write,
	.notify_enable_in, .msg_ready, .notify_enable, .select_valid,
	.msg_valid, .event_identifier, .msg_timestamp, .msg_frame);

// *** tb/host_sink.sv ***
// Host-side model that takes event messages and can stall the channel
`timescale 1ns/1ps
module host_sink
	import event_notifier_pkg::*;
(
	input  wire logic               ref_clk,          // Clock
	input  wire logic               stall,            // Hold off accepting
	input  wire logic               msg_valid,        // Message offered
	input  wire logic [15:0]        event_identifier, // Message id
	input  wire logic [TS_W-1:0]    msg_timestamp,    // Message time
	input  wire logic [FRAME_W-1:0] msg_frame,        // Message frame
	output logic                    msg_ready         // Accepting
);
	logic [15:0]        got_id[$];
	logic [TS_W-1:0]    got_ts[$];
	logic [FRAME_W-1:0] got_frame[$];

	assign msg_ready = !stall;

	// Bench stalls whenever it freezes the design, so no false accepts
	always @(posedge ref_clk) begin
		if (msg_valid && msg_ready) begin
			got_id.push_back(event_identifier);
			got_ts.push_back(msg_timestamp);
			got_frame.push_back(msg_frame);
		end
	end
endmodule

// *** tb/camera_event_notifier_tb.sv ***
// Self-checking bench for the camera event notifier
`timescale 1ns/1ps
module camera_event_notifier_tb;
	import event_notifier_pkg::*;
	logic        ref_clk = 0, reset = 1, clk_en = 1, wr = 0, en_in = 0;
	logic        line = 0, stall = 0, ne, sv, mv, rdy;
	logic [4:0]  sel = 5'h00;
	logic [11:0] ev = 12'h000;
	logic [63:0] ts = 64'h0, mts;
	logic [31:0] fr = 32'h0, mfr;
	logic [15:0] id;
	logic        mono_sv, mono_mv;
	logic [15:0] mono_id;
	logic [63:0] mono_mts;
	logic [31:0] mono_mfr;
	int          fails = 0, checks = 0;
	localparam logic [15:0] IDS [12] = '{16'h9011, 16'h9012, 16'h9300,
		16'h9301, 16'h9302, 16'h9303, 16'h9304, 16'h9305, 16'h9306,
		16'h9307, 16'h9330, 16'h9331};

	always #50 ref_clk = ~ref_clk;

	camera_event_notifier #(.COLOR_MODEL(1'b1)) dut_u (.ref_clk(ref_clk),
		.reset(reset), .clk_en(clk_en), .event_source_select(sel),
		.notify_write(wr), .notify_enable_in(en_in),
		.capture_begin(ev[0]), .capture_end(ev[1]), .frame_begin(ev[2]),
		.frame_end_a(ev[3]), .exposure_begin({ev[8], ev[6], ev[4]}),
		.exposure_end({ev[9], ev[7], ev[5]}), .line_active_window(line),
		.timestamp(ts), .frame_sequence_number(fr), .msg_ready(rdy),
		.notify_enable(ne), .select_valid(sv), .msg_valid(mv),
		.event_identifier(id), .msg_timestamp(mts), .msg_frame(mfr));

	// Monochrome build on the same stimulus, judged straight off its ports
	camera_event_notifier #(.COLOR_MODEL(1'b0)) mono_u (.ref_clk(ref_clk),
		.reset(reset), .clk_en(clk_en), .event_source_select(sel),
		.notify_write(wr), .notify_enable_in(en_in),
		.capture_begin(ev[0]), .capture_end(ev[1]), .frame_begin(ev[2]),
		.frame_end_a(ev[3]), .exposure_begin({ev[8], ev[6], ev[4]}),
		.exposure_end({ev[9], ev[7], ev[5]}), .line_active_window(line),
		.timestamp(ts), .frame_sequence_number(fr), .msg_ready(rdy),
		.notify_enable(), .select_valid(mono_sv), .msg_valid(mono_mv),
		.event_identifier(mono_id), .msg_timestamp(mono_mts),
		.msg_frame(mono_mfr));

	host_sink sink_u (.ref_clk(ref_clk), .stall(stall), .msg_valid(mv),
		.event_identifier(id), .msg_timestamp(mts), .msg_frame(mfr),
		.msg_ready(rdy));

	// ========================================================================
	// Shared tasks
	task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic results;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	function automatic logic [4:0] code(int k);
		return (k < 10) ? 5'(k) : 5'(k + 18);
	endfunction

	task automatic set_en(int k, logic v);
		sel = code(k);
		wr = 1;
		en_in = v;
		@(negedge ref_clk);
		wr = 0;
		@(negedge ref_clk);
		check("enable", 64'(ne), 64'(v));
	endtask

	// Line events come from edges of the level input
	task automatic fire(int k);
		ts = 64'h0123_4567_0000_0000 + 64'(k * 7);
		fr = 32'(k + 100);
		if (k == 10) line = 1;
		else if (k == 11) line = 0;
		else ev[k] = 1;
		@(negedge ref_clk);
		ev = 12'h000;
	endtask

	task automatic expect_msg(int k, logic [63:0] t, logic [31:0] f);
		int          n;
		logic [15:0] got;
		n = 0;
		while (sink_u.got_id.size() == 0 && n < 20) begin
			@(negedge ref_clk);
			n++;
		end
		check("arrived", 64'(sink_u.got_id.size() > 0), 64'h1);
		if (sink_u.got_id.size() > 0) begin
			got = sink_u.got_id.pop_front();
			check("id", 64'(got), 64'(IDS[k]));
			check("ts", sink_u.got_ts.pop_front(), t);
			check("frame", 64'(sink_u.got_frame.pop_front()), 64'(f));
		end
	endtask

	// ========================================================================
	// Scenarios
	task automatic t_select;
		for (int k = 0; k < 12; k++) begin
			sel = code(k);
			repeat (2) @(negedge ref_clk);
			check("mapped", 64'(sv), 64'h1);
			check("off", 64'(ne), 64'h0);
			check("mono map", 64'(mono_sv), 64'(!(k inside {4, 5, 8, 9})));
		end
		sel = 5'h0a;
		wr = 1;
		en_in = 1;
		@(negedge ref_clk);
		wr = 0;
		@(negedge ref_clk);
		check("unmapped", 64'(sv), 64'h0);
		check("mono unmapped", 64'(mono_sv), 64'h0);
		check("refused", 64'(ne), 64'h0);
	endtask

	task automatic t_each;
		for (int k = 0; k < 12; k++) begin
			set_en(k, 1);
			fire(k);
			expect_msg(k, ts, fr);
		end
	endtask

	// Three sources at once while the host stalls and the design freezes
	task automatic t_burst;
		stall = 1;
		ts = 64'hfeed_0000_0000_0042;
		fr = 32'h0000_0777;
		ev = 12'h109;
		@(negedge ref_clk);
		ev = 12'h000;
		repeat (3) @(negedge ref_clk);
		clk_en = 0;
		repeat (3) @(negedge ref_clk);
		check("held", 64'(mv), 64'h1);
		clk_en = 1;
		stall = 0;
		expect_msg(0, ts, fr);
		expect_msg(3, ts, fr);
		expect_msg(8, ts, fr);
	endtask

	task automatic t_off;
		set_en(0, 0);
		fire(0);
		repeat (6) @(negedge ref_clk);
		check("dropped", 64'(sink_u.got_id.size()), 64'h0);
	endtask

	// Red and green begin together: mono keeps only green as the exposure
	task automatic t_mono;
		ts = 64'h0000_0abc_0000_0001;
		fr = 32'h0000_0055;
		ev = 12'h050;
		@(negedge ref_clk);
		ev = 12'h000;
		@(negedge ref_clk);
		check("mono valid", 64'(mono_mv), 64'h1);
		check("mono id", 64'(mono_id), 64'h9304);
		check("mono ts", mono_mts, ts);
		check("mono frame", 64'(mono_mfr), 64'(fr));
		repeat (4) begin
			@(negedge ref_clk);
			check("mono red", 64'(mono_mv), 64'h0);
		end
		expect_msg(4, ts, fr);
		expect_msg(6, ts, fr);
	endtask

	initial begin
		repeat (5) @(negedge ref_clk);
		check("reset ts", mts, 64'h0);
		check("reset valid", 64'(mv), 64'h0);
		reset = 0;
		t_select();
		t_each();
		t_burst();
		t_off();
		t_mono();
		results();
	end

	// Whole run is well under 1000 cycles
	initial begin
		#500000;
		fails++;
		results();
	end
endmodule
